// *** hw/rhs_pkg.sv ***
// Constants and types for the reset and hang supervision block.
// Assumes a single 100 MHz clock and a host that drives the reset pins.
// Behaviour
// - Power-up of a chained domain (7 to 15) coinciding with hard reset hangs the sequencer.
// - During hang the reset state output stays low.
// - Only full or power-on reset clears the hang; hard reset not.
// - System reset removes core power and clears debug state.
`default_nettype none
package rhs_pkg;
    localparam int RHS_NUM_DOMAINS = 16;
    localparam int RHS_CFG_W = 16;
    localparam int RHS_CORES = 8;
    localparam int RHS_FIRST_CHAIN = 7;
    localparam int RHS_LAST_CHAIN = 15;
    // Reset hold after all reset inputs drop
    localparam int RHS_RELEASE_NS = 100;
    localparam int RHS_CLK_NS = 10;
    localparam int RHS_RELEASE_CYC = (RHS_RELEASE_NS + RHS_CLK_NS - 1) / RHS_CLK_NS;
    localparam int RHS_CNT_W = 8;
    localparam logic [RHS_CNT_W-1:0] RHS_CNT_ZERO = 8'h00;
    typedef enum logic [1:0] {RHS_IN_RESET, RHS_RELEASE, RHS_RUN, RHS_HUNG} rhs_state_t;
endpackage : rhs_pkg
`default_nettype wire

// *** hw/rhs_if.sv ***
// Carries domain power state between the supervisor and the sequencer.
// Assumes one clock shared by both ends.
`default_nettype none
interface rhs_if;
    import rhs_pkg::*;
    logic [RHS_NUM_DOMAINS-1:0] on;
    logic [RHS_NUM_DOMAINS-1:0] in_transition;
    logic hang;
    logic sys_reset;
    logic clear_hang;
    modport ctrl (input on, input in_transition, input hang, output sys_reset, output clear_hang);
    modport seq (output on, output in_transition, output hang, input sys_reset, input clear_hang);
endinterface : rhs_if
`default_nettype wire

// *** hw/rhs_power_sleep_sequencer.sv ***
// Per-domain power sequencer with daisy-chain hang behaviour.
// Assumes power-up requests are single-cycle and synchronous.
`default_nettype none
module rhs_power_sleep_sequencer (
    input wire logic clk,
    input wire logic rst,
    input wire logic [rhs_pkg::RHS_NUM_DOMAINS-1:0] pwr_up_req,
    input wire logic [rhs_pkg::RHS_NUM_DOMAINS-1:0] pwr_dn_req,
    rhs_if.seq bus
);
    import rhs_pkg::*;
    logic [RHS_NUM_DOMAINS-1:0] on_r, on_nxt, tr_r, tr_nxt;
    logic hang_r, hang_nxt;

    function automatic logic is_chained(input int d);
        return (d >= RHS_FIRST_CHAIN) && (d <= RHS_LAST_CHAIN);
    endfunction : is_chained

    always_comb begin
        on_nxt = on_r;
        tr_nxt = tr_r;
        hang_nxt = hang_r;
        for (int d = 0; d < RHS_NUM_DOMAINS; d++) begin
            if (bus.sys_reset) begin
                if (tr_r[d] && is_chained(d))
                    hang_nxt = 1'b1;
                if (d >= RHS_FIRST_CHAIN + 1)
                    on_nxt[d] = 1'b0;
                if (!(tr_r[d] && is_chained(d)))
                    tr_nxt[d] = 1'b0;
            end else if (!hang_r) begin
                if (tr_r[d]) begin
                    tr_nxt[d] = 1'b0;
                    on_nxt[d] = 1'b1;
                end else if (pwr_up_req[d] && !on_r[d]) begin
                    tr_nxt[d] = 1'b1;
                end else if (pwr_dn_req[d]) begin
                    on_nxt[d] = 1'b0;
                end
            end
        end
        if (bus.clear_hang) begin
            hang_nxt = 1'b0;
            tr_nxt = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_r <= '0;
            tr_r <= '0;
            hang_r <= 1'b0;
        end else begin
            on_r <= on_nxt;
            tr_r <= tr_nxt;
            hang_r <= hang_nxt;
        end
    end

    assign bus.on = on_r;
    assign bus.in_transition = tr_r;
    assign bus.hang = hang_r;
endmodule : rhs_power_sleep_sequencer
`default_nettype wire

// *** hw/rhs_reset_supervisor.sv ***
// Top: device reset controller with power-domain hang behaviour.
// Assumes host inputs are synchronous to CLOCK; RESET is the power-on reset.
`default_nettype none
module rhs_reset_supervisor #(
    parameter int RELEASE_CYC = rhs_pkg::RHS_RELEASE_CYC
) (
    // Clock and power-on reset
    input wire logic CLOCK,
    input wire logic RESET,
    // Host reset requests
    input wire logic HARD_RESET_IN,
    input wire logic FULL_RESET_IN,
    input wire logic DEBUG_SYS_RESET,
    input wire logic [rhs_pkg::RHS_CFG_W-1:0] BOOT_CFG_IN,
    // Software domain power control
    input wire logic [rhs_pkg::RHS_NUM_DOMAINS-1:0] PWR_UP_REQ,
    input wire logic [rhs_pkg::RHS_NUM_DOMAINS-1:0] PWR_DN_REQ,
    // Status
    output logic RESET_STATE_OUT,
    output logic [rhs_pkg::RHS_CFG_W-1:0] BOOT_CFG_LATCHED,
    output logic [rhs_pkg::RHS_NUM_DOMAINS-1:0] DOMAIN_ON,
    output logic [rhs_pkg::RHS_CORES-1:0] DEBUG_BKPT_VALID,
    output logic HANG_FLAG
);
    import rhs_pkg::*;

    // Release count must fit the down-counter
    if (RELEASE_CYC < 1 || RELEASE_CYC > (1 << RHS_CNT_W) - 1) begin : g_bad_release
        $error("RELEASE_CYC out of range");
    end

    rhs_if pbus ();
    rhs_state_t state_r, state_nxt;
    logic [RHS_CNT_W-1:0] cnt_r, cnt_nxt;
    logic stat_r, stat_nxt;
    logic [RHS_CFG_W-1:0] cfg_r, cfg_nxt;
    logic [RHS_CORES-1:0] bkpt_r, bkpt_nxt;
    logic sys_rst;
    logic full_rst;

    assign full_rst = FULL_RESET_IN;
    assign sys_rst = HARD_RESET_IN || DEBUG_SYS_RESET || FULL_RESET_IN;
    assign pbus.sys_reset = sys_rst;
    assign pbus.clear_hang = full_rst;

    rhs_power_sleep_sequencer u_seq (
        .clk(CLOCK),
        .rst(RESET),
        .pwr_up_req(PWR_UP_REQ),
        .pwr_dn_req(PWR_DN_REQ),
        .bus(pbus)
    );

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        stat_nxt = stat_r;
        cfg_nxt = cfg_r;
        bkpt_nxt = bkpt_r;
        unique case (state_r)
            RHS_IN_RESET: begin
                stat_nxt = 1'b0;
                // Boot config re-latched during full reset
                if (full_rst)
                    cfg_nxt = BOOT_CFG_IN;
                if (!sys_rst) begin
                    state_nxt = RHS_RELEASE;
                    cnt_nxt = RELEASE_CYC[RHS_CNT_W-1:0];
                end
            end
            RHS_RELEASE: begin
                if (sys_rst) begin
                    state_nxt = RHS_IN_RESET;
                end else if (pbus.hang) begin
                    state_nxt = RHS_HUNG;
                end else if (cnt_r == RHS_CNT_ZERO) begin
                    state_nxt = RHS_RUN;
                    stat_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            RHS_RUN: begin
                if (sys_rst) begin
                    state_nxt = RHS_IN_RESET;
                    stat_nxt = 1'b0;
                end
            end
            RHS_HUNG: begin
                stat_nxt = 1'b0;
                if (full_rst)
                    state_nxt = RHS_IN_RESET;
            end
        endcase
        if (sys_rst)
            bkpt_nxt = '0;
        else if (state_r == RHS_RUN)
            bkpt_nxt = pbus.on[RHS_NUM_DOMAINS-1:RHS_NUM_DOMAINS-RHS_CORES];
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            state_r <= RHS_IN_RESET;
            cnt_r <= RHS_CNT_ZERO;
            stat_r <= 1'b0;
            cfg_r <= '0;
            bkpt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            stat_r <= stat_nxt;
            cfg_r <= cfg_nxt;
            bkpt_r <= bkpt_nxt;
        end
    end

    // Power-on reset shows BOOT_CFG_IN for one cycle right after release, then cfg_r
    logic por_seen_r, por_seen_nxt;
    logic [RHS_CFG_W-1:0] cfg_out_r, cfg_out_nxt;
    always_comb begin
        por_seen_nxt = 1'b1;
        cfg_out_nxt = por_seen_r ? cfg_r : BOOT_CFG_IN;
        if (por_seen_r && full_rst)
            cfg_out_nxt = BOOT_CFG_IN;
    end
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            por_seen_r <= 1'b0;
            cfg_out_r <= '0;
        end else begin
            por_seen_r <= por_seen_nxt;
            cfg_out_r <= cfg_out_nxt;
        end
    end

    assign RESET_STATE_OUT = stat_r;
    assign BOOT_CFG_LATCHED = cfg_out_r;
    assign DOMAIN_ON = pbus.on;
    assign DEBUG_BKPT_VALID = bkpt_r;
    assign HANG_FLAG = pbus.hang;
endmodule : rhs_reset_supervisor
`default_nettype wire

// *** tb/rhs_sva.sv ***
// Checker for the reset supervisor top ports.
// Assumes one clock domain and RESET as its async reset.
`default_nettype none
module rhs_sva (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // Watched ports
    input wire logic HARD_RESET_IN,
    input wire logic FULL_RESET_IN,
    input wire logic DEBUG_SYS_RESET,
    input wire logic [15:0] PWR_UP_REQ,
    input wire logic RESET_STATE_OUT,
    input wire logic [15:0] DOMAIN_ON,
    input wire logic [7:0] DEBUG_BKPT_VALID,
    input wire logic HANG_FLAG
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    hang_entry_a: assert property (RESET_STATE_OUT && !HANG_FLAG && !HARD_RESET_IN && !FULL_RESET_IN &&
        !DEBUG_SYS_RESET && |(PWR_UP_REQ[15:7] & ~DOMAIN_ON[15:7]) ##1 HARD_RESET_IN && !FULL_RESET_IN
        |=> HANG_FLAG) else $error("no hang after chained power-up with hard reset");
    hang_low_a: assert property (HANG_FLAG |-> !RESET_STATE_OUT) else $error("status high while hung");
    hang_hold_a: assert property (HANG_FLAG && !FULL_RESET_IN |=> HANG_FLAG) else $error("hang lost");
    hang_clear_a: assert property (HANG_FLAG && FULL_RESET_IN |=> !HANG_FLAG) else $error("hang kept");
    sys_reset_a: assert property (HARD_RESET_IN || DEBUG_SYS_RESET |=> !RESET_STATE_OUT &&
        DEBUG_BKPT_VALID == 8'h00 && DOMAIN_ON[15:8] == 8'h00) else $error("system reset left state");
endmodule : rhs_sva
bind rhs_reset_supervisor rhs_sva i_sva (.CLOCK(CLOCK), .RESET(RESET), .HARD_RESET_IN(HARD_RESET_IN),
    .FULL_RESET_IN(FULL_RESET_IN), .DEBUG_SYS_RESET(DEBUG_SYS_RESET), .PWR_UP_REQ(PWR_UP_REQ),
    .RESET_STATE_OUT(RESET_STATE_OUT), .DOMAIN_ON(DOMAIN_ON), .DEBUG_BKPT_VALID(DEBUG_BKPT_VALID),
    .HANG_FLAG(HANG_FLAG));
`default_nettype wire

// *** tb/rhs_host.sv ***
// Behavioural host that drives the hard and full reset pins.
// Assumes its tasks are called at a falling clock edge.
`default_nettype none
module rhs_host #(
    parameter int TIMEOUT = 40
) (
    input wire logic CLOCK,
    input wire logic RESET_STATE_OUT,
    output logic HARD_RESET_IN,
    output logic FULL_RESET_IN,
    output logic [15:0] BOOT_CFG_IN
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        HARD_RESET_IN = 1'b0;
        FULL_RESET_IN = 1'b0;
        BOOT_CFG_IN = 16'h0000;
    end
    task automatic wait_up(output bit ok);
        ok = 1'b0;
        for (int i = 0; i < TIMEOUT && !ok; i++) begin
            @(negedge CLOCK);
            ok = (RESET_STATE_OUT === 1'b1);
        end
    endtask : wait_up
    task automatic hard_reset(input logic [15:0] cfg, input bit full, output bit hung, output bit rec);
        HARD_RESET_IN = 1'b1;
        repeat (2) @(negedge CLOCK);
        HARD_RESET_IN = 1'b0;
        wait_up(rec);
        hung = !rec;
        if (hung && full) begin
            BOOT_CFG_IN = cfg;
            FULL_RESET_IN = 1'b1;
            repeat (3) @(negedge CLOCK);
            FULL_RESET_IN = 1'b0;
            wait_up(rec);
        end
    endtask : hard_reset
endmodule : rhs_host
`default_nettype wire

// *** tb/rhs_reset_supervisor_tb.sv ***
// Self-checking bench for the reset supervisor with a host model.
// Assumes the bound checker and a shortened release count.
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module rhs_reset_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 2;
    logic clock = 1'b0, reset = 1'b1, dbg = 1'b0, hard, full, status, hang;
    logic [15:0] cfg, cfg_q, up = 16'h0000, dn = 16'h0000, on;
    logic [7:0] bkpt;
    int errors = 0, n_tests = 0;
    rhs_reset_supervisor #(.RELEASE_CYC(RC)) i_dut (.CLOCK(clock), .RESET(reset), .HARD_RESET_IN(hard),
        .FULL_RESET_IN(full), .DEBUG_SYS_RESET(dbg), .BOOT_CFG_IN(cfg), .PWR_UP_REQ(up), .PWR_DN_REQ(dn),
        .RESET_STATE_OUT(status), .BOOT_CFG_LATCHED(cfg_q), .DOMAIN_ON(on), .DEBUG_BKPT_VALID(bkpt),
        .HANG_FLAG(hang));
    rhs_host i_host (.CLOCK(clock), .RESET_STATE_OUT(status), .HARD_RESET_IN(hard), .FULL_RESET_IN(full),
        .BOOT_CFG_IN(cfg));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic conclude;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    task automatic rise_cycles(output int k);
        for (k = 0; k < 60 && status !== 1'b1; k++) @(negedge clock);
        if (status !== 1'b1) begin
            errors++;
            conclude();
        end
    endtask : rise_cycles
    task automatic pulse(input logic [15:0] u, input logic [15:0] d);
        up = u;
        dn = d;
        @(negedge clock);
        up = 16'h0000;
        dn = 16'h0000;
    endtask : pulse
    task automatic host_rst(input int dom, input logic [15:0] c, input bit fl, input bit exp_hang);
        bit hung, rec;
        if (dom >= 0) pulse(16'h0001 << dom, 16'h0000);
        i_host.hard_reset(c, fl, hung, rec);
        `CHK("hung", exp_hang, hung)
        `CHK("hang_flag", !rec, hang)
        if (!rec && (fl || !exp_hang)) begin
            errors++;
            conclude();
        end
    endtask : host_rst
    task automatic t_por;
        int k;
        repeat (8) @(negedge clock);
        reset = 1'b0;
        rise_cycles(k);
        `CHK("release", RC + 2, k)
        `CHK("cfg_por", 16'h0000, cfg_q)
        $display("t_por done");
    endtask : t_por
    task automatic t_hang;
        for (int i = 0; i < 3; i++) begin
            host_rst(i == 0 ? 7 : (i == 1 ? 8 : 15), 16'hA5C0 + 16'(i), 1'b0, 1'b1);
            host_rst(-1, 16'h0000, 1'b0, 1'b1);
            host_rst(-1, 16'h5A30 + 16'(i), 1'b1, 1'b1);
            `CHK("status", 1'b1, status)
            `CHK("cfg", 16'h5A30 + 16'(i), cfg_q)
        end
        host_rst(6, 16'h0000, 1'b1, 1'b0);
        $display("t_hang done");
    endtask : t_hang
    task automatic t_sysrst;
        int k;
        pulse(16'h0204, 16'h0000);
        @(negedge clock);
        `CHK("dom_up", 16'h0204, on & 16'h0204)
        pulse(16'h0000, 16'h0004);
        repeat (3) @(negedge clock);
        `CHK("dom_dn", 1'b0, on[2])
        `CHK("bkpt_run", 8'h02, bkpt)
        dbg = 1'b1;
        @(negedge clock);
        dbg = 1'b0;
        `CHK("status", 1'b0, status)
        `CHK("bkpt", 8'h00, bkpt)
        `CHK("cores", 8'h00, on[15:8])
        rise_cycles(k);
        `CHK("rerelease", RC + 2, k)
        $display("t_sysrst done");
    endtask : t_sysrst
    initial begin
        t_por();
        t_hang();
        t_sysrst();
        conclude();
    end
endmodule : rhs_reset_supervisor_tb
`default_nettype wire
